// ==== rtl/erd_pkg.sv ====
// Purpose: shared constants and types for the rx descriptor dma
// Assumes: 32-bit system bus, 32-bit apb, little-endian descriptors
// Notes: apb map and frame flag order are local choices
// Overview of operation
// - word 0 bit 31 set means dma owns; dma clears it when done.
// - bit 30 on destination filter fail, bit 13 on source filter fail.
// - frame length in bits 29:16, written only in the last descriptor.
// - bit 15 is the or of bits 0,1,3,4,6,7,11,14.
// - bit 14 when buffer too small and next descriptor host-owned.
// - bit 12 length mismatch, only with frame type set, crc good.
// - bit 11 when receive fifo overflowed during the frame.
// - bit 10 vlan tagged; bit 5 ethernet type, clear for 802.3.
// - bit 9 on first buffer descriptor, bit 8 on last one.
// - bit 7 header checksum error if checking, else giant over 1518.
// - bit 6 on late collision in half duplex.
// - bit 4 on receive watchdog timeout.
// - bit 3 when phy error and data valid both asserted.
// - bit 2 dribble, non-whole byte count, only in mii mode.
// - bit 1 crc error, only in the last descriptor.
// - bit 0 address block 1-15 hit, or payload checksum with offload.
// - control bit 31 suppresses the receive-complete status pulse.
// - end-of-ring bit 25 makes the list base the next address.
// - chain bit 24: buffer-2 word is next pointer; ring overrides.
// - any buffer address accepted; low address bits ignored.

package erd_pkg;
    // ****************************************************************
    // apb register map
    // ****************************************************************
    localparam logic [7:0] ERD_OFS_CTRL = 8'h00;
    localparam logic [7:0] ERD_OFS_BASE = 8'h04;
    localparam logic [7:0] ERD_OFS_POLL = 8'h08;
    localparam logic [7:0] ERD_OFS_STAT = 8'h0c;
    localparam logic [7:0] ERD_OFS_CUR = 8'h10;
    localparam logic [7:0] ERD_OFS_FCNT = 8'h14;
    localparam int ERD_CTRL_EN = 0;
    localparam int ERD_CTRL_HCHK = 1;
    localparam int ERD_CTRL_FOFF = 2;
    localparam int ERD_CTRL_MII = 3;
    localparam int ERD_CTRL_W = 4;
    localparam logic [3:0] ERD_CTRL_RST = 4'h0;

    // ****************************************************************
    // descriptor layout
    // ****************************************************************
    localparam int ERD_OWN = 31;
    localparam int ERD_NOIRQ = 31;
    localparam int ERD_RING = 25;
    localparam int ERD_CHAIN = 24;
    localparam int ERD_BS2_HI = 21;
    localparam int ERD_BS2_LO = 11;
    localparam int ERD_BS1_HI = 10;
    localparam int ERD_BS_W = 11;
    localparam int ERD_LEN_W = 14;
    localparam logic [31:0] ERD_DESC_BYTES = 32'h0000_0010;
    localparam logic [31:0] ERD_WORD_BYTES = 32'h0000_0004;
    localparam logic [13:0] ERD_GIANT_LEN = 14'd1518;

    // ****************************************************************
    // frame flag vector positions
    // ****************************************************************
    localparam int ERD_FL_DEST = 0;
    localparam int ERD_FL_SRC = 1;
    localparam int ERD_FL_LENMIS = 2;
    localparam int ERD_FL_OVF = 3;
    localparam int ERD_FL_VLAN = 4;
    localparam int ERD_FL_ETH = 5;
    localparam int ERD_FL_HCSUM = 6;
    localparam int ERD_FL_LCOL = 7;
    localparam int ERD_FL_WDOG = 8;
    localparam int ERD_FL_RXER = 9;
    localparam int ERD_FL_DRIB = 10;
    localparam int ERD_FL_CRC = 11;
    localparam int ERD_FL_ABLK = 12;
    localparam int ERD_FL_PCSUM = 13;
    localparam int ERD_FL_W = 14;

    typedef enum logic [2:0] {
        ERD_IDLE, ERD_FETCH, ERD_PEEK, ERD_WAIT, ERD_WRITE, ERD_SUSP
    } erd_state_e;
endpackage

// ==== rtl/erd_stat_if.sv ====
// Purpose: carries one frame's facts to the status packer
// Assumes: single ref_clk domain, combinational use only
// Notes: word is the finished descriptor status word
`timescale 1ns/1ps
`default_nettype none
interface erd_stat_if;
    import erd_pkg::*;
    logic [ERD_FL_W-1:0] flags;
    logic [ERD_LEN_W-1:0] len;
    logic first;
    logic last;
    logic desc_err;
    logic hdr_chk;
    logic full_off;
    logic mii;
    logic [31:0] word;
    modport pack (input flags, len, first, last, desc_err, hdr_chk,
        full_off, mii, output word);
    modport user (output flags, len, first, last, desc_err, hdr_chk,
        full_off, mii, input word);
endinterface
`default_nettype wire

// ==== rtl/erd_status_pack.sv ====
// Purpose: builds the status word written back to descriptor word 0
// Assumes: flags stable while the write is pending
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
module erd_status_pack
    import erd_pkg::*;
(
    // frame facts in, word out
    erd_stat_if.pack s
);
    logic err_sum;
    logic [31:0] w;

    // ****************************************************************
    // field assembly
    // ****************************************************************
    always_comb begin
        w = 32'h0000_0000;
        w[31] = 1'b0;
        w[30] = s.flags[ERD_FL_DEST];
        w[13] = s.flags[ERD_FL_SRC];
        w[29:16] = s.last ? s.len : 14'h0000;
        w[14] = s.desc_err;
        w[12] = s.flags[ERD_FL_LENMIS] & s.flags[ERD_FL_ETH]
            & ~s.flags[ERD_FL_CRC];
        w[11] = s.flags[ERD_FL_OVF];
        w[10] = s.flags[ERD_FL_VLAN];
        w[5] = s.flags[ERD_FL_ETH];
        w[9] = s.first;
        w[8] = s.last;
        w[7] = s.hdr_chk ? s.flags[ERD_FL_HCSUM] : (s.len > ERD_GIANT_LEN);
        w[6] = s.flags[ERD_FL_LCOL];
        w[4] = s.flags[ERD_FL_WDOG];
        w[3] = s.flags[ERD_FL_RXER];
        w[2] = s.flags[ERD_FL_DRIB] & s.mii;
        w[1] = s.flags[ERD_FL_CRC] & s.last;
        w[0] = s.full_off ? s.flags[ERD_FL_PCSUM] : s.flags[ERD_FL_ABLK];
        err_sum = w[0] | w[1] | w[3] | w[4] | w[6] | w[7] | w[11] | w[14];
        w[15] = err_sum;
        s.word = w;
    end
endmodule // erd_status_pack
`default_nettype wire

// ==== rtl/erd_next_addr.sv ====
// Purpose: next descriptor address from ring and chain bits
// Assumes: descriptors 16 bytes apart when neither bit is set
// Notes: low address bits below the bus width are dropped from ring and chain targets
`timescale 1ns/1ps
`default_nettype none
module erd_next_addr
    import erd_pkg::*;
#(
    parameter int ALIGN_BITS = 2
) (
    // descriptor context
    input wire logic [31:0] cur,
    input wire logic [31:0] base,
    input wire logic [31:0] ctrl_word,
    input wire logic [31:0] buf2_word,
    // results
    output logic [31:0] next,
    output logic use_buf2
);
    localparam logic [31:0] MASK = ~((32'h1 << ALIGN_BITS) - 32'h1);

    // ring wins over chain
    always_comb begin
        use_buf2 = ~ctrl_word[ERD_CHAIN] | ctrl_word[ERD_RING];
        if (ctrl_word[ERD_RING]) begin
            next = base & MASK;
        end else if (ctrl_word[ERD_CHAIN]) begin
            next = buf2_word & MASK;
        end else begin
            next = cur + ERD_DESC_BYTES;
        end
    end
endmodule // erd_next_addr
`default_nettype wire

// ==== rtl/erd_rx_desc_dma.sv ====
// Purpose: receive descriptor fetch, ownership and status write-back
// Assumes: memory port answers with a one-cycle mem_gnt, same clock
// Notes: frame data movement is outside; only lengths are tracked
`timescale 1ns/1ps
`default_nettype none
module erd_rx_desc_dma
    import erd_pkg::*;
#(
    parameter int ALIGN_BITS = 2
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // apb slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // descriptor memory master
    output logic mem_req,
    output logic mem_we,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    input wire logic mem_gnt,
    input wire logic [31:0] mem_rdata,
    // frame end report from receive path
    input wire logic frm_valid,
    input wire logic [ERD_LEN_W-1:0] frm_len,
    input wire logic [ERD_FL_W-1:0] frm_flags,
    output logic frm_ready,
    // receive-complete status pulse
    output logic rx_complete_irq_status
);
    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        erd_state_e st;
        logic [1:0] widx;
        logic [31:0] cur;
        logic [31:0] base;
        logic [31:0] w0;
        logic [31:0] w1;
        logic [31:0] w2;
        logic [31:0] w3;
        logic nxt_own;
        logic [ERD_CTRL_W-1:0] ctrl;
        logic poll;
        logic [ERD_LEN_W-1:0] len;
        logic [ERD_FL_W-1:0] flags;
        logic [ERD_LEN_W-1:0] rem;
        logic cont;
        logic [15:0] fcnt;
        logic mem_req;
        logic mem_we;
        logic [31:0] mem_addr;
        logic [31:0] mem_wdata;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic frm_ready;
        logic irq;
    } erd_regs_s;

    erd_regs_s st_ff;
    erd_regs_s nxt_st;
    logic [31:0] next_addr;
    logic use_buf2;
    logic [ERD_LEN_W-1:0] cap;
    logic fits;
    logic last_now;
    logic de_now;
    logic apb_wr;
    logic [31:0] rd_val;
    logic rd_hit;

    erd_stat_if sif ();

    // all checks below sample on the one clock, quiet in reset
    default clocking cb_chk @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    // ****************************************************************
    // helpers
    // ****************************************************************
    erd_next_addr #(.ALIGN_BITS(ALIGN_BITS)) u_next (
        .cur(st_ff.cur),
        .base(st_ff.base),
        .ctrl_word(st_ff.w1),
        .buf2_word(st_ff.w3),
        .next(next_addr),
        .use_buf2(use_buf2)
    );

    erd_status_pack u_pack (
        .s(sif.pack)
    );

    // capacity of this descriptor; buffer 2 only when not chained or when the ring bit is set
    always_comb begin
        cap = ERD_LEN_W'(st_ff.w1[ERD_BS1_HI:0])
            + (use_buf2 ? ERD_LEN_W'(st_ff.w1[ERD_BS2_HI:ERD_BS2_LO])
                        : {ERD_LEN_W{1'b0}});
        fits = st_ff.rem <= cap;
        de_now = ~fits & ~st_ff.nxt_own;
        last_now = fits | ~st_ff.nxt_own;
    end

    // frame facts toward the packer
    assign sif.flags = st_ff.flags;
    assign sif.len = st_ff.len;
    assign sif.first = ~st_ff.cont;
    assign sif.last = last_now;
    assign sif.desc_err = de_now;
    assign sif.hdr_chk = st_ff.ctrl[ERD_CTRL_HCHK];
    assign sif.full_off = st_ff.ctrl[ERD_CTRL_FOFF];
    assign sif.mii = st_ff.ctrl[ERD_CTRL_MII];

    // ****************************************************************
    // apb decode
    // ****************************************************************
    always_comb begin
        rd_hit = 1'b1;
        rd_val = 32'h0000_0000;
        unique case (paddr)
            ERD_OFS_CTRL: rd_val = {28'h0000000, st_ff.ctrl};
            ERD_OFS_BASE: rd_val = st_ff.base;
            ERD_OFS_POLL: rd_val = 32'h0000_0000;
            ERD_OFS_STAT: rd_val = {28'h0000000, st_ff.nxt_own, st_ff.st};
            ERD_OFS_CUR: rd_val = st_ff.cur;
            ERD_OFS_FCNT: rd_val = {16'h0000, st_ff.fcnt};
            default: rd_hit = 1'b0;
        endcase
    end

    // write lands at the edge that samples pready high
    assign apb_wr = psel & penable & pwrite & st_ff.pready & rd_hit;

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        nxt_st = st_ff;
        nxt_st.irq = 1'b0;
        nxt_st.pready = psel & ~penable;
        if (psel & ~penable) begin
            nxt_st.prdata = rd_val;
            nxt_st.pslverr = ~rd_hit;
        end
        if (apb_wr) begin
            unique case (paddr)
                ERD_OFS_CTRL: nxt_st.ctrl = pwdata[ERD_CTRL_W-1:0];
                ERD_OFS_BASE: nxt_st.base = pwdata;
                ERD_OFS_POLL: nxt_st.poll = 1'b1;
                default: ;
            endcase
        end
        // memory request drops on its grant
        if (st_ff.mem_req & mem_gnt) begin
            nxt_st.mem_req = 1'b0;
        end
        unique case (st_ff.st)
            ERD_IDLE: begin
                if (st_ff.ctrl[ERD_CTRL_EN]) begin
                    nxt_st.cur = st_ff.base;
                    nxt_st.widx = 2'd0;
                    nxt_st.st = ERD_FETCH;
                end
            end
            ERD_FETCH: begin
                if (!st_ff.mem_req) begin
                    nxt_st.mem_req = 1'b1;
                    nxt_st.mem_we = 1'b0;
                    nxt_st.mem_addr = st_ff.cur
                        + ERD_WORD_BYTES * {30'h0, st_ff.widx};
                end else if (mem_gnt) begin
                    nxt_st.widx = st_ff.widx + 2'd1;
                    unique case (st_ff.widx)
                        2'd0: nxt_st.w0 = mem_rdata;
                        2'd1: nxt_st.w1 = mem_rdata;
                        2'd2: nxt_st.w2 = mem_rdata;
                        2'd3: nxt_st.w3 = mem_rdata;
                    endcase
                    if (st_ff.widx == 2'd0 && !mem_rdata[ERD_OWN]) begin
                        nxt_st.poll = 1'b0;
                        nxt_st.st = ERD_SUSP;
                    end else if (st_ff.widx == 2'd3) begin
                        nxt_st.st = ERD_PEEK;
                    end
                end
            end
            // look one descriptor ahead
            ERD_PEEK: begin
                if (!st_ff.mem_req) begin
                    nxt_st.mem_req = 1'b1;
                    nxt_st.mem_we = 1'b0;
                    nxt_st.mem_addr = next_addr;
                end else if (mem_gnt) begin
                    nxt_st.nxt_own = mem_rdata[ERD_OWN];
                    nxt_st.st = st_ff.cont ? ERD_WRITE : ERD_WAIT;
                end
            end
            ERD_WAIT: begin
                if (frm_valid & st_ff.frm_ready) begin
                    nxt_st.len = frm_len;
                    nxt_st.rem = frm_len;
                    nxt_st.flags = frm_flags;
                    nxt_st.st = ERD_WRITE;
                end else if (!st_ff.ctrl[ERD_CTRL_EN]) begin
                    nxt_st.st = ERD_IDLE;
                end
            end
            // status back to word 0, ownership returned
            ERD_WRITE: begin
                if (!st_ff.mem_req) begin
                    nxt_st.mem_req = 1'b1;
                    nxt_st.mem_we = 1'b1;
                    nxt_st.mem_addr = st_ff.cur;
                    nxt_st.mem_wdata = sif.word;
                end else if (mem_gnt) begin
                    nxt_st.cur = next_addr;
                    nxt_st.widx = 2'd0;
                    nxt_st.st = ERD_FETCH;
                    if (last_now) begin
                        nxt_st.cont = 1'b0;
                        nxt_st.fcnt = st_ff.fcnt + 16'h0001;
                        nxt_st.irq = ~st_ff.w1[ERD_NOIRQ];
                    end else begin
                        nxt_st.cont = 1'b1;
                        nxt_st.rem = st_ff.rem - cap;
                    end
                end
            end
            // parked until software polls or disables
            ERD_SUSP: begin
                if (!st_ff.ctrl[ERD_CTRL_EN]) begin
                    nxt_st.st = ERD_IDLE;
                end else if (st_ff.poll) begin
                    nxt_st.poll = 1'b0;
                    nxt_st.widx = 2'd0;
                    nxt_st.st = ERD_FETCH;
                end
            end
            default: nxt_st.st = ERD_IDLE;
        endcase
        // a spill lost to host reclaim drops the frame tail
        if (nxt_st.st != ERD_WRITE && nxt_st.st != ERD_FETCH
            && nxt_st.st != ERD_PEEK) begin
            nxt_st.cont = 1'b0;
        end
        nxt_st.frm_ready = (nxt_st.st == ERD_WAIT) && !nxt_st.cont;
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st_ff <= '0;
            st_ff.st <= ERD_IDLE;
            st_ff.ctrl <= ERD_CTRL_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs straight from the state flops
    assign prdata = st_ff.prdata;
    assign pready = st_ff.pready;
    assign pslverr = st_ff.pslverr;
    assign mem_req = st_ff.mem_req;
    assign mem_we = st_ff.mem_we;
    assign mem_addr = st_ff.mem_addr;
    assign mem_wdata = st_ff.mem_wdata;
    assign frm_ready = st_ff.frm_ready;
    assign rx_complete_irq_status = st_ff.irq;

    // ****************************************************************
    // checks
    // ****************************************************************
    // a status write-back taken by memory
    sequence s_wr_done;
        st_ff.st == ERD_WRITE && mem_req && mem_gnt;
    endsequence

    // word k of the current descriptor taken by memory
    sequence s_rd_word(int k);
        st_ff.st == ERD_FETCH && mem_req && mem_gnt && st_ff.widx == k;
    endsequence

    AST_OWN_CLR: assert property (
        mem_req && mem_we |-> !mem_wdata[ERD_OWN])
        else $error("write-back left ownership with dma");
    AST_LEN_LAST: assert property (
        mem_req && mem_we && mem_wdata[8] |-> mem_wdata[29:16] == st_ff.len)
        else $error("length missing from last descriptor");
    // summary is the or of its sources
    AST_ERR_SUM: assert property (
        mem_req && mem_we |-> mem_wdata[15] == |{mem_wdata[14],
        mem_wdata[11], mem_wdata[7:6], mem_wdata[4:3], mem_wdata[1:0]})
        else $error("error summary mismatch");
    AST_DE_SPILL: assert property (
        mem_req && mem_we && mem_wdata[14] |-> mem_wdata[8])
        else $error("descriptor error without last mark");
    AST_FIRST: assert property (
        s_wr_done and !st_ff.cont |-> mem_wdata[9])
        else $error("first buffer mark missing");
    AST_IRQ: assert property (
        s_wr_done and mem_wdata[8] |=>
        rx_complete_irq_status == !$past(st_ff.w1[ERD_NOIRQ]))
        else $error("completion pulse wrong");
    AST_RING: assert property (
        s_wr_done and st_ff.w1[ERD_RING] |=> st_ff.cur == st_ff.base)
        else $error("ring did not wrap");
    AST_FETCH_SEQ: assert property (
        s_rd_word(0) and mem_rdata[ERD_OWN] |-> ##[1:64] s_rd_word(1)
        ##0 (mem_addr == st_ff.cur + ERD_WORD_BYTES))
        else $error("descriptor words not consecutive");
    AST_GIANT: assert property (
        mem_req && mem_we && !st_ff.ctrl[ERD_CTRL_HCHK] |->
        mem_wdata[7] == (st_ff.len > ERD_GIANT_LEN))
        else $error("giant flag wrong");
    // crc flag only on the last descriptor
    AST_CRC_LAST: assert property (
        mem_req && mem_we && mem_wdata[1] |-> mem_wdata[8])
        else $error("crc flag outside last descriptor");
    // dribble flag only in mii mode
    AST_DRIB_MII: assert property (
        mem_req && mem_we && !st_ff.ctrl[ERD_CTRL_MII] |-> !mem_wdata[2])
        else $error("dribble flag outside mii mode");
endmodule // erd_rx_desc_dma
`default_nettype wire

// ==== tb/erd_mem_model.sv ====
// Purpose: host memory holding rx descriptors for the dma
// Assumes: one word per address, granted after lat idle cycles
// Notes: lines no longer granted toggle so stale reads show up
`timescale 1ns/1ps
`default_nettype none
module erd_mem_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // memory slave side
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    output logic mem_gnt,
    output logic [31:0] mem_rdata,
    // grant delay in cycles
    input wire logic [3:0] lat
);
    // ********************
    // descriptor store
    // ********************
    // host fills: own set, three in list, sizes of 4
    logic [31:0] mem [0:15];
    logic [3:0] wait_cnt;

    // one word per grant; write-back lands at the grant
    always @(posedge ref_clk) begin
        if (reset) begin
            mem_gnt <= 1'b0;
            wait_cnt <= 4'h0;
            mem_rdata <= 32'h5a5a_a5a5;
        end else if (!mem_gnt && mem_req && wait_cnt >= lat) begin
            mem_gnt <= 1'b1;
            mem_rdata <= mem_we ? ~mem_rdata : mem[mem_addr[5:2]];
            if (mem_we) mem[mem_addr[5:2]] <= mem_wdata;
        end else begin
            mem_gnt <= 1'b0; // one-cycle pulse only
            wait_cnt <= (mem_req && !mem_gnt) ? wait_cnt + 4'h1 : 4'h0;
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule // erd_mem_model
`default_nettype wire

// ==== tb/erd_rx_desc_dma_tb.sv ====
// Purpose: self-checking bench for the rx descriptor dma
// Assumes: apb answers after one access cycle or more
// Notes: three frames over a list, only its second link chained, that wraps at the ring end
`timescale 1ns/1ps
`default_nettype none
module erd_rx_desc_dma_tb
    import erd_pkg::*;
;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic pready, pslverr, mem_req, mem_we, mem_gnt, frm_ready, irq, err;
    logic [31:0] prdata, mem_addr, mem_wdata, mem_rdata, rd, ex, next_rd;
    logic frm_valid = 1'b0, after_wr = 1'b0;
    logic [ERD_LEN_W-1:0] frm_len = 14'h0;
    logic [ERD_FL_W-1:0] frm_flags = 14'h0;
    logic [3:0] lat = 4'h0;
    int miscompares = 0, checks_done = 0, irq_cnt = 0, exp_irq = 0;
    // frame table: mode, flags, length, slot, control, next pointer
    logic [3:0] t_ctl [3] = '{4'h1, 4'hf, 4'h9};
    logic [13:0] t_fl [3] = '{14'h1551, 14'h2eee, 14'h0024};
    logic [13:0] t_len [3] = '{14'h05ef, 14'h0040, 14'h05ee};
    logic [31:0] t_at [3] = '{32'h00, 32'h10, 32'h30};
    // last slot is too small and its next slot is already returned
    logic [31:0] t_cw [3] = '{32'h7fc, 32'h8100_07fc, 32'h0300_0400};
    logic [31:0] t_w3 [3] = '{32'h0, 32'h33, 32'h20}; // unaligned chain
    logic [31:0] t_nxt [3] = '{32'h10, 32'h30, 32'h0};

    always #12.5 ref_clk = ~ref_clk;

    erd_rx_desc_dma #(.ALIGN_BITS(2)) dut (.ref_clk(ref_clk),
        .reset(reset), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_gnt(mem_gnt), .mem_rdata(mem_rdata), .frm_valid(frm_valid),
        .frm_len(frm_len), .frm_flags(frm_flags), .frm_ready(frm_ready),
        .rx_complete_irq_status(irq));
    erd_mem_model u_mem (.ref_clk(ref_clk), .reset(reset),
        .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_gnt(mem_gnt), .mem_rdata(mem_rdata),
        .lat(lat));

    // ********************
    // monitors and helpers
    // ********************
    // first read after a write-back shows the next descriptor chosen
    always @(posedge ref_clk) begin
        if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
        if (mem_gnt === 1'b1 && mem_we === 1'b1) after_wr <= 1'b1;
        if (mem_gnt === 1'b1 && mem_we === 1'b0 && after_wr) begin
            next_rd <= mem_addr;
            after_wr <= 1'b0;
        end
    end

    // expected status word built bit by bit from the frame facts
    function automatic logic [31:0] exp_st(int i);
        logic [13:0] f;
        logic [31:0] s;
        f = t_fl[i];
        s = {2'b00, t_len[i], 16'h0300}; // single buffer: first and last
        s[30] = f[0];
        s[14] = t_len[i] > t_cw[i][10:0]; // spill onto a host-owned slot
        s[13] = f[1];
        s[12] = f[2] & f[5] & ~f[11]; // ethernet type and good crc only
        s[11] = f[3];
        s[10] = f[4];
        s[7] = t_ctl[i][1] ? f[6] : (t_len[i] > 14'd1518);
        s[6] = f[7];
        s[5] = f[5];
        s[4] = f[8];
        s[3] = f[9];
        s[2] = f[10] & t_ctl[i][3]; // mii mode only
        s[1] = f[11];
        s[0] = t_ctl[i][2] ? f[13] : f[12];
        s[15] = |{s[0], s[1], s[3], s[4], s[6], s[7], s[11], s[14]};
        return s;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // one apb transfer, held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] r, output logic e);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ********************
    // test sequence
    // ********************
    initial begin
        for (int k = 0; k < 3; k++) begin
            u_mem.mem[t_at[k][5:2]] = 32'h8000_0000;
            u_mem.mem[t_at[k][5:2] + 1] = t_cw[k];
            u_mem.mem[t_at[k][5:2] + 2] = 32'h0000_0103; // unaligned
            u_mem.mem[t_at[k][5:2] + 3] = t_w3[k];
        end
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        apb(1'b0, ERD_OFS_CTRL, 32'h0, rd, err);
        chk(rd, 32'h0);
        apb(1'b0, 8'h18, 32'h0, rd, err);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, ERD_OFS_BASE, 32'h0, rd, err);
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, ERD_OFS_CTRL, {28'h0, t_ctl[i]}, rd, err);
            if (i == 0) apb(1'b1, ERD_OFS_POLL, 32'h1, rd, err);
            lat <= lat + 4'h3; // memory answers slower each frame
            frm_valid <= 1'b1;
            frm_len <= t_len[i];
            frm_flags <= t_fl[i];
            // taken at the edge that sees frm_ready high
            do @(posedge ref_clk); while (frm_ready !== 1'b1);
            frm_valid <= 1'b0;
            while (u_mem.mem[t_at[i][5:2]][31] !== 1'b0) @(posedge ref_clk);
            repeat (16) @(posedge ref_clk);
            if (!t_cw[i][31]) exp_irq++;
            rd = u_mem.mem[t_at[i][5:2]];
            ex = exp_st(i);
            chk(rd >> 16, ex >> 16);
            chk(rd & 32'hff00, ex & 32'hff00);
            chk(rd & 32'hff, ex & 32'hff);
            chk(32'(irq_cnt), 32'(exp_irq));
            chk(next_rd, t_nxt[i]);
        end
        // ring wrapped onto a returned slot: engine parks
        apb(1'b0, ERD_OFS_STAT, 32'h0, rd, err);
        chk(rd, {28'h0, 1'b0, ERD_SUSP});
        apb(1'b0, ERD_OFS_FCNT, 32'h0, rd, err);
        chk(rd, 32'h3);
        finish_test();
    end

    // watchdog well beyond three frames
    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        finish_test();
    end
endmodule // erd_rx_desc_dma_tb
`default_nettype wire
